// [pkg/fppio_pkg.sv]
package fppio_pkg;

   localparam int          FPPIO_NUM_PORTS  = 5;
   localparam int          FPPIO_PORT_W     = 8;
   localparam int          FPPIO_ADDR_W     = 6;

   // port indices: first .. fifth port
   localparam int          FPPIO_PORT_A     = 0;
   localparam int          FPPIO_PORT_B     = 1;
   localparam int          FPPIO_PORT_C     = 2;
   localparam int          FPPIO_PORT_D     = 3;
   localparam int          FPPIO_PORT_E     = 4;

   // implemented bits of each port, fifth port first
   localparam logic [FPPIO_NUM_PORTS-1:0][7:0] FPPIO_PORT_MASK =
      {8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'hFF};

   // register map
   localparam logic [FPPIO_ADDR_W-1:0] FPPIO_DATA_BASE = 6'h00;
   localparam logic [FPPIO_ADDR_W-1:0] FPPIO_PULL_BASE = 6'h08;
   localparam logic [FPPIO_ADDR_W-1:0] FPPIO_DIR_BASE  = 6'h10;
   localparam logic [FPPIO_ADDR_W-1:0] FPPIO_CFG_ADDR  = 6'h18;

   // configuration register fields
   localparam int          FPPIO_CFG_DBG_BIT    = 0;
   localparam int          FPPIO_CFG_RSTPIN_BIT = 1;
   localparam int          FPPIO_CFG_MS_BIT     = 7;
   localparam logic [1:0]  FPPIO_CFG_RESET      = 2'h3;

   // reset values
   localparam logic [7:0]  FPPIO_DATA_RESET = 8'h00;
   localparam logic [7:0]  FPPIO_DIR_RESET  = 8'h00;
   localparam logic [7:0]  FPPIO_PULL_RESET = 8'h00;

   // shared-function bit positions
   localparam int          FPPIO_IN_ONLY_BIT = 0;
   localparam int          FPPIO_SCI_TX_BIT  = 0;
   localparam int          FPPIO_SCI_RX_BIT  = 1;
   localparam int          FPPIO_TPM1_BIT    = 7;
   localparam int          FPPIO_SPI_LO_BIT  = 4;
   localparam int          FPPIO_KEYPAD_IRQ_UNIT_TWO_W      = 4;
   localparam int          FPPIO_DBG_BIT     = 0;
   localparam int          FPPIO_RSTPIN_BIT  = 1;
   localparam int          FPPIO_TPM0_BIT    = 6;
   localparam logic [7:0]  FPPIO_PD_CAP_MASK = 8'hF0;
   localparam logic [7:0]  FPPIO_D_PIN_READ  = 8'h03;

   function automatic logic fppio_hit(input logic [FPPIO_ADDR_W-1:0] addr,
                                      input logic [FPPIO_ADDR_W-1:0] base,
                                      input int                      port);
      return addr == (base + FPPIO_ADDR_W'(port));
   endfunction : fppio_hit

endpackage : fppio_pkg

// [core/fppio_sync.sv]
`timescale 1ns/1ps
module fppio_sync_stage #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // no reset: the chain must keep sampling while reset is held
   always_ff @(posedge clk) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
   end
endmodule : fppio_sync_stage

// [core/fppio_port.sv]
`timescale 1ns/1ps
module fppio_port_drive #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] latch,
   input  wire logic [W-1:0] dir,
   input  wire logic [W-1:0] pull_en,
   input  wire logic [W-1:0] own,
   input  wire logic [W-1:0] own_oe,
   input  wire logic [W-1:0] own_out,
   input  wire logic [W-1:0] force_pu,
   input  wire logic [W-1:0] pd_req,
   input  wire logic [W-1:0] in_only,
   output logic      [W-1:0] pin_out,
   output logic      [W-1:0] pin_oe,
   output logic      [W-1:0] pin_pu,
   output logic      [W-1:0] pin_pd
);
   logic [W-1:0] oe_d;
   logic [W-1:0] out_d;
   logic [W-1:0] pull_on;

   always_comb begin
      // peripheral sets direction when it owns the pin
      oe_d    = ((own & own_oe) | (~own & dir)) & ~in_only;
      out_d   = (own & own_out) | (~own & latch);
      pull_on = pull_en & ~dir;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out <= '0;
         pin_oe  <= '0;
         pin_pu  <= force_pu;
         pin_pd  <= '0;
      end else begin
         pin_out <= out_d;
         pin_oe  <= oe_d;
         pin_pu  <= (pull_on & ~pd_req) | force_pu;
         pin_pd  <= pull_on & pd_req & ~force_pu;
      end
   end
endmodule : fppio_port_drive

// [core/fppio_top.sv]
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module fppio_top
   import fppio_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [FPPIO_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [7:0]              reg_rdata,

   // pins, one group per port
   input  wire logic [7:0]              port0_in,
   output logic      [7:0]              port0_out,
   output logic      [7:0]              port0_oe,
   output logic      [7:0]              port0_pu,
   output logic      [7:0]              port0_pd,

   input  wire logic [7:0]              port1_in,
   output logic      [7:0]              port1_out,
   output logic      [7:0]              port1_oe,
   output logic      [7:0]              port1_pu,
   output logic      [7:0]              port1_pd,

   input  wire logic [7:0]              port2_in,
   output logic      [7:0]              port2_out,
   output logic      [7:0]              port2_oe,
   output logic      [7:0]              port2_pu,
   output logic      [7:0]              port2_pd,

   input  wire logic [6:0]              port3_in,
   output logic      [6:0]              port3_out,
   output logic      [6:0]              port3_oe,
   output logic      [6:0]              port3_pu,
   output logic      [6:0]              port3_pd,

   input  wire logic [7:0]              port4_in,
   output logic      [7:0]              port4_out,
   output logic      [7:0]              port4_oe,
   output logic      [7:0]              port4_pu,
   output logic      [7:0]              port4_pd,

   // synchronized pin levels for the on-chip peripherals
   output logic      [7:0]              port0_level,
   output logic      [7:0]              port1_level,
   output logic      [7:0]              port2_level,
   output logic      [6:0]              port3_level,
   output logic      [7:0]              port4_level,

   // peripheral claims, same clock domain
   input  wire logic [7:0]              keypad_one_sel,
   input  wire logic [7:0]              keypad_one_rise,
   input  wire logic [3:0]              keypad_two_sel,
   input  wire logic                    serial_en,
   input  wire logic                    serial_txd,
   input  wire logic                    timer_ch1_own,
   input  wire logic                    timer_ch1_oe,
   input  wire logic                    timer_ch1_out,
   input  wire logic                    spi_en,
   input  wire logic [3:0]              spi_oe,
   input  wire logic [3:0]              spi_out,
   input  wire logic                    timer_ch0_own,
   input  wire logic                    timer_ch0_oe,
   input  wire logic                    timer_ch0_out,
   input  wire logic                    debug_oe,
   input  wire logic                    debug_out,
   output logic                         debug_pin_en,
   output logic                         reset_pin_en,
   output logic                         mode_select
);
   localparam int NP = FPPIO_NUM_PORTS;

   // software-visible registers, one word per port
   logic [7:0]   data_q [NP];
   logic [7:0]   dir_q  [NP];
   logic [7:0]   pull_q [NP];

   // pin levels before and after the synchronizer
   logic [7:0]   pin_in [NP];
   logic [7:0]   lvl    [NP];

   // ownership decoded from the peripheral claims
   logic [7:0]   own    [NP];
   logic [7:0]   own_oe [NP];
   logic [7:0]   own_out[NP];
   logic [7:0]   frc_pu [NP];
   logic [7:0]   pd_req [NP];
   logic [7:0]   in_only[NP];

   // registered pin drive from the per-port stage
   logic [7:0]   d_out  [NP];
   logic [7:0]   d_oe   [NP];
   logic [7:0]   d_pu   [NP];
   logic [7:0]   d_pd   [NP];

   // read path and system pin functions
   logic [7:0]   rd_val [NP];
   logic         dbg_en_q;
   logic         rstpin_en_q;
   logic         ms_q;
   logic [7:0]   rdata_d;
   logic [7:0]   rdata_q_w;

   // absent eighth bit of the fourth port reads a quiet low
   assign pin_in[FPPIO_PORT_A] = port0_in;
   assign pin_in[FPPIO_PORT_B] = port1_in;
   assign pin_in[FPPIO_PORT_C] = port2_in;
   assign pin_in[FPPIO_PORT_D] = {1'b0, port3_in};
   assign pin_in[FPPIO_PORT_E] = port4_in;

   // per-port synchronizer and pin drive
   for (genvar p = 0; p < NP; p++) begin : g_port
      fppio_sync_stage #(.W(8)) u_sync (
         .clk      (clk),
         .async_in (pin_in[p]),
         .sync_out (lvl[p])
      );

      // outputs are registered in the drive stage, so pins never glitch
      fppio_port_drive #(.W(8)) u_drive (
         .clk      (clk),
         .rst      (rst),
         .latch    (data_q[p]),
         .dir      (dir_q[p]),
         .pull_en  (pull_q[p]),
         .own      (own[p]),
         .own_oe   (own_oe[p]),
         .own_out  (own_out[p]),
         .force_pu (frc_pu[p]),
         .pd_req   (pd_req[p]),
         .in_only  (in_only[p]),
         .pin_out  (d_out[p]),
         .pin_oe   (d_oe[p]),
         .pin_pu   (d_pu[p]),
         .pin_pd   (d_pd[p])
      );
   end

   assign port0_out   = d_out[FPPIO_PORT_A];
   assign port0_oe    = d_oe [FPPIO_PORT_A];
   assign port0_pu    = d_pu [FPPIO_PORT_A];
   assign port0_pd    = d_pd [FPPIO_PORT_A];

   assign port1_out   = d_out[FPPIO_PORT_B];
   assign port1_oe    = d_oe [FPPIO_PORT_B];
   assign port1_pu    = d_pu [FPPIO_PORT_B];
   assign port1_pd    = d_pd [FPPIO_PORT_B];

   assign port2_out   = d_out[FPPIO_PORT_C];
   assign port2_oe    = d_oe [FPPIO_PORT_C];
   assign port2_pu    = d_pu [FPPIO_PORT_C];
   assign port2_pd    = d_pd [FPPIO_PORT_C];

   assign port3_out   = d_out[FPPIO_PORT_D][6:0];
   assign port3_oe    = d_oe [FPPIO_PORT_D][6:0];
   assign port3_pu    = d_pu [FPPIO_PORT_D][6:0];
   assign port3_pd    = d_pd [FPPIO_PORT_D][6:0];

   assign port4_out   = d_out[FPPIO_PORT_E];
   assign port4_oe    = d_oe [FPPIO_PORT_E];
   assign port4_pu    = d_pu [FPPIO_PORT_E];
   assign port4_pd    = d_pd [FPPIO_PORT_E];

   assign port0_level = lvl[FPPIO_PORT_A];
   assign port1_level = lvl[FPPIO_PORT_B];
   assign port2_level = lvl[FPPIO_PORT_C];
   assign port3_level = lvl[FPPIO_PORT_D][6:0];
   assign port4_level = lvl[FPPIO_PORT_E];

   assign debug_pin_en = dbg_en_q;
   assign reset_pin_en = rstpin_en_q;
   assign mode_select  = ms_q;
   assign reg_rdata    = rdata_q_w;

   // latch, pullup and direction registers
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int p = 0; p < NP; p++) begin
            data_q[p] <= FPPIO_DATA_RESET;
            dir_q[p]  <= FPPIO_DIR_RESET;
            pull_q[p] <= FPPIO_PULL_RESET;
         end
      end else if (reg_wr) begin
         // unimplemented bits never store a one, so they read back low
         for (int p = 0; p < NP; p++) begin
            // the latch takes the write whoever owns the pin
            if (fppio_hit(reg_addr, FPPIO_DATA_BASE, p))
               data_q[p] <= reg_wdata & FPPIO_PORT_MASK[p];
            if (fppio_hit(reg_addr, FPPIO_PULL_BASE, p))
               pull_q[p] <= reg_wdata & FPPIO_PORT_MASK[p];
            if (fppio_hit(reg_addr, FPPIO_DIR_BASE, p))
               dir_q[p]  <= reg_wdata & FPPIO_PORT_MASK[p];
         end
      end
   end

   // system pin function enables, both claimed from reset onward
   always_ff @(posedge clk) begin
      if (rst) begin
         dbg_en_q    <= FPPIO_CFG_RESET[FPPIO_CFG_DBG_BIT];
         rstpin_en_q <= FPPIO_CFG_RESET[FPPIO_CFG_RSTPIN_BIT];
      end else if (reg_wr && reg_addr == FPPIO_CFG_ADDR) begin
         // the mode-select bit is captured, never written
         dbg_en_q    <= reg_wdata[FPPIO_CFG_DBG_BIT];
         rstpin_en_q <= reg_wdata[FPPIO_CFG_RSTPIN_BIT];
      end
   end

   // mode select is sampled from the debug pin while reset is held
   // the last level before release stays; reset must outlast the sync chain
   // the debug pullup is on in reset, so a floating pin reads as one
   always_ff @(posedge clk) begin
      if (rst)
         ms_q <= lvl[FPPIO_PORT_D][FPPIO_DBG_BIT];
   end

   // peripheral and system ownership of pins
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         own[p]     = 8'h00;
         own_oe[p]  = 8'h00;
         own_out[p] = 8'h00;
         frc_pu[p]  = 8'h00;
         pd_req[p]  = 8'h00;
         in_only[p] = ~FPPIO_PORT_MASK[p];
      end

      // first port: keypad inputs, never driven by the unit
      own[FPPIO_PORT_A]                    = keypad_one_sel;
      pd_req[FPPIO_PORT_A]                 = keypad_one_sel & keypad_one_rise
                                             & FPPIO_PD_CAP_MASK;
      in_only[FPPIO_PORT_A][FPPIO_IN_ONLY_BIT] = 1'b1;

      // second port: serial pair and timer channel
      if (serial_en) begin
         own[FPPIO_PORT_B][FPPIO_SCI_TX_BIT]     = 1'b1;
         own_oe[FPPIO_PORT_B][FPPIO_SCI_TX_BIT]  = 1'b1;
         own_out[FPPIO_PORT_B][FPPIO_SCI_TX_BIT] = serial_txd;
         // receive pin: claimed but never driven
         own[FPPIO_PORT_B][FPPIO_SCI_RX_BIT]     = 1'b1;
      end
      // the timer sets direction itself, so capture leaves the pin undriven
      if (timer_ch1_own) begin
         own[FPPIO_PORT_B][FPPIO_TPM1_BIT]     = 1'b1;
         own_oe[FPPIO_PORT_B][FPPIO_TPM1_BIT]  = timer_ch1_oe;
         own_out[FPPIO_PORT_B][FPPIO_TPM1_BIT] = timer_ch1_out;
      end

      // third port: SPI on the high nibble, keypad two on the low one
      // index 0 of the SPI vectors is the lowest of the four pins
      if (spi_en) begin
         own[FPPIO_PORT_C][FPPIO_SPI_LO_BIT +: 4]     = 4'hF;
         own_oe[FPPIO_PORT_C][FPPIO_SPI_LO_BIT +: 4]  = spi_oe;
         own_out[FPPIO_PORT_C][FPPIO_SPI_LO_BIT +: 4] = spi_out;
      end
      own[FPPIO_PORT_C][FPPIO_KEYPAD_IRQ_UNIT_TWO_W-1:0] = keypad_two_sel;

      // fourth port: debug pin, reset pin, timer channel
      if (dbg_en_q) begin
         // the debug unit only drives once reset has ended
         own[FPPIO_PORT_D][FPPIO_DBG_BIT]     = 1'b1;
         own_oe[FPPIO_PORT_D][FPPIO_DBG_BIT]  = debug_oe & ~rst;
         own_out[FPPIO_PORT_D][FPPIO_DBG_BIT] = debug_out;
         frc_pu[FPPIO_PORT_D][FPPIO_DBG_BIT]  = 1'b1;
      end
      // the reset pin is never driven here; its pull follows the register
      if (rstpin_en_q)
         own[FPPIO_PORT_D][FPPIO_RSTPIN_BIT] = 1'b1;
      // an external timer clock arrives with the timer's enable low
      if (timer_ch0_own) begin
         own[FPPIO_PORT_D][FPPIO_TPM0_BIT]     = 1'b1;
         own_oe[FPPIO_PORT_D][FPPIO_TPM0_BIT]  = timer_ch0_oe;
         own_out[FPPIO_PORT_D][FPPIO_TPM0_BIT] = timer_ch0_out;
      end
   end

   // read source per bit; software should load data before dir
   always_comb begin
      for (int p = 0; p < NP; p++)
         rd_val[p] = ((dir_q[p] & data_q[p]) | (~dir_q[p] & lvl[p]))
                     & FPPIO_PORT_MASK[p];

      // debug and reset pins report the pin itself whatever the direction
      rd_val[FPPIO_PORT_D] = (rd_val[FPPIO_PORT_D] & ~FPPIO_D_PIN_READ)
                             | (lvl[FPPIO_PORT_D] & FPPIO_D_PIN_READ);
   end

   // read mux: the three register maps never overlap, so order is free
   always_comb begin
      rdata_d = 8'h00;
      for (int p = 0; p < NP; p++) begin
         if (fppio_hit(reg_addr, FPPIO_DATA_BASE, p))
            rdata_d = rd_val[p];
         if (fppio_hit(reg_addr, FPPIO_PULL_BASE, p))
            rdata_d = pull_q[p];
         if (fppio_hit(reg_addr, FPPIO_DIR_BASE, p))
            rdata_d = dir_q[p];
      end
      // the captured mode-select level reads in the top bit
      if (reg_addr == FPPIO_CFG_ADDR) begin
         rdata_d[FPPIO_CFG_DBG_BIT]    = dbg_en_q;
         rdata_d[FPPIO_CFG_RSTPIN_BIT] = rstpin_en_q;
         rdata_d[FPPIO_CFG_MS_BIT]     = ms_q;
      end
   end

   // read data stands only in the cycle after the strobe
   // zero between reads so a stale value never looks like an answer
   always_ff @(posedge clk) begin
      if (rst)
         rdata_q_w <= 8'h00;
      else if (reg_rd)
         rdata_q_w <= rdata_d;
      else
         rdata_q_w <= 8'h00;
   end

endmodule : fppio_top

// [dv/fppio_top_asserts.sv]
`timescale 1ns/1ps
module fppio_top_asserts (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic [7:0] port0_oe,
   input  wire logic [7:0] port0_pu,
   input  wire logic [7:0] port0_pd,
   input  wire logic [7:0] port1_oe,
   input  wire logic [7:0] port1_out,
   input  wire logic [7:0] port2_oe,
   input  wire logic [7:0] port2_out,
   input  wire logic [6:0] port3_oe,
   input  wire logic [6:0] port3_pu,
   input  wire logic [7:0] port4_in,
   input  wire logic [7:0] port4_oe,
   input  wire logic [7:0] port4_pu,
   input  wire logic [7:0] port4_level,
   input  wire logic       serial_en,
   input  wire logic       serial_txd,
   input  wire logic       timer_ch1_own,
   input  wire logic       timer_ch1_oe,
   input  wire logic       spi_en,
   input  wire logic [3:0] spi_oe,
   input  wire logic [3:0] spi_out,
   input  wire logic       timer_ch0_own,
   input  wire logic       timer_ch0_oe,
   input  wire logic       debug_pin_en,
   input  wire logic       mode_select
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // registered outputs only settle after two edges of reset
   logic [1:0] rst_run_q = 2'h0;
   always_ff @(posedge clk) begin
      if (!rst) rst_run_q <= 2'h0;
      else if (rst_run_q != 2'h3) rst_run_q <= rst_run_q + 2'h1;
   end

   chk_reset_quiet: assert property (disable iff (1'b0)
      rst_run_q >= 2'h2 |-> (port0_oe | port4_oe) == 8'h00) else $error("driven in reset");
   chk_in_only_bit: assert property (port0_oe[0] == 1'b0)
      else $error("input-only pin driven");
   chk_sync_depth: assert property (port4_level == $past(port4_in, 2))
      else $error("level not two stages late");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside its cycle");
   chk_serial_tx: assert property (serial_en |=>
      port1_oe[0] && port1_out[0] == $past(serial_txd)) else $error("serial transmit pin");
   chk_serial_rx: assert property (serial_en |=> !port1_oe[1])
      else $error("serial receive pin driven");
   chk_spi_pins: assert property (spi_en |=> port2_oe[7:4] == $past(spi_oe)
      && port2_out[7:4] == $past(spi_out)) else $error("spi pins");
   chk_timer_second: assert property (timer_ch1_own |=>
      port1_oe[7] == $past(timer_ch1_oe)) else $error("timer pin second port");
   chk_timer_fourth: assert property (timer_ch0_own |=>
      port3_oe[6] == $past(timer_ch0_oe)) else $error("timer pin fourth port");
   chk_debug_pull: assert property (debug_pin_en |=> port3_pu[0])
      else $error("debug pullup off");
   chk_output_pull: assert property ((port4_oe & port4_pu) == 8'h00)
      else $error("pullup on output");
   chk_pull_excl: assert property ((port0_pu & port0_pd) == 8'h00)
      else $error("pullup and pulldown together");
   chk_mode_hold: assert property (!$past(rst) |-> $stable(mode_select))
      else $error("mode select changed after reset");

   cover property (serial_en ##1 port1_oe[0]);
   cover property (spi_en ##1 port2_oe[7:4] != 4'h0);
   cover property ($fell(debug_pin_en));
   cover property (port0_pd[7:4] == 4'hF);
endmodule : fppio_top_asserts

bind fppio_top fppio_top_asserts chk_u (.clk, .rst, .reg_rd, .reg_rdata, .port0_oe, .port0_pu,
   .port0_pd, .port1_oe, .port1_out, .port2_oe, .port2_out, .port3_oe, .port3_pu, .port4_in,
   .port4_oe, .port4_pu, .port4_level, .serial_en, .serial_txd, .timer_ch1_own, .timer_ch1_oe,
   .spi_en, .spi_oe, .spi_out, .timer_ch0_own, .timer_ch0_oe, .debug_pin_en, .mode_select);

// [dv/fppio_board.sv]
`timescale 1ns/1ps
module fppio_board (
   input  wire logic        clk,
   input  wire logic [39:0] pin_out,
   input  wire logic [39:0] pin_oe,
   input  wire logic [39:0] pin_pu,
   input  wire logic [39:0] pin_pd,
   input  wire logic [39:0] ext_en,
   input  wire logic [39:0] ext_val,
   output logic      [39:0] pin_lvl
);
   // an undriven, unpulled pin toggles so a stale level never reads as valid
   logic [39:0] flip_q = 40'h0;
   always_ff @(posedge clk) begin
      flip_q <= ~flip_q;
   end
   always_comb begin
      for (int i = 0; i < 40; i++) begin
         if (pin_oe[i]) pin_lvl[i] = pin_out[i];
         else if (ext_en[i]) pin_lvl[i] = ext_val[i];
         else if (pin_pu[i]) pin_lvl[i] = 1'b1;
         else if (pin_pd[i]) pin_lvl[i] = 1'b0;
         else pin_lvl[i] = flip_q[i];
      end
   end
endmodule : fppio_board

// [dv/fppio_top_test.sv]
`timescale 1ns/1ps
module fppio_top_test;
   import fppio_pkg::*;
   logic                    clk, rst, reg_wr, reg_rd;
   logic [FPPIO_ADDR_W-1:0] reg_addr;
   logic [7:0]              reg_wdata, keypad_one_sel, keypad_one_rise, pat, exp;
   logic [3:0]              keypad_two_sel, spi_oe, spi_out;
   logic                    serial_en, serial_txd, timer_ch1_own, timer_ch1_oe, timer_ch1_out;
   logic                    spi_en, timer_ch0_own, timer_ch0_oe, timer_ch0_out;
   logic                    debug_oe, debug_out;
   logic [39:0]             ext_en, ext_val;
   wire  [7:0]              reg_rdata;
   wire                     debug_pin_en, reset_pin_en, mode_select;
   wire  [39:0]             pin_out, pin_oe, pin_pu, pin_pd, pin_lvl, pin_sync;
   int                      num_errors = 0;
   int                      n_compared = 0;

   assign {pin_out[31], pin_oe[31], pin_pu[31], pin_pd[31], pin_sync[31]} = 5'h0;

   fppio_top dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .port0_in(pin_lvl[7:0]), .port0_out(pin_out[7:0]), .port0_oe(pin_oe[7:0]),
      .port0_pu(pin_pu[7:0]), .port0_pd(pin_pd[7:0]), .port0_level(pin_sync[7:0]),
      .port1_in(pin_lvl[15:8]), .port1_out(pin_out[15:8]), .port1_oe(pin_oe[15:8]),
      .port1_pu(pin_pu[15:8]), .port1_pd(pin_pd[15:8]), .port1_level(pin_sync[15:8]),
      .port2_in(pin_lvl[23:16]), .port2_out(pin_out[23:16]), .port2_oe(pin_oe[23:16]),
      .port2_pu(pin_pu[23:16]), .port2_pd(pin_pd[23:16]), .port2_level(pin_sync[23:16]),
      .port3_in(pin_lvl[30:24]), .port3_out(pin_out[30:24]), .port3_oe(pin_oe[30:24]),
      .port3_pu(pin_pu[30:24]), .port3_pd(pin_pd[30:24]), .port3_level(pin_sync[30:24]),
      .port4_in(pin_lvl[39:32]), .port4_out(pin_out[39:32]), .port4_oe(pin_oe[39:32]),
      .port4_pu(pin_pu[39:32]), .port4_pd(pin_pd[39:32]), .port4_level(pin_sync[39:32]),
      .keypad_one_sel, .keypad_one_rise, .keypad_two_sel, .serial_en, .serial_txd,
      .timer_ch1_own, .timer_ch1_oe, .timer_ch1_out, .spi_en, .spi_oe, .spi_out,
      .timer_ch0_own, .timer_ch0_oe, .timer_ch0_out, .debug_oe, .debug_out,
      .debug_pin_en, .reset_pin_en, .mode_select);

   fppio_board board_u (.clk, .pin_out, .pin_oe, .pin_pu, .pin_pd, .ext_en, .ext_val, .pin_lvl);

   function automatic logic [5:0] reg_at(input logic [5:0] b, input int p);
      return b + 6'(p);
   endfunction : reg_at

   task automatic check(input logic [7:0] got, input logic [7:0] e, input string what);
      n_compared++;
      if (got !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, e);
      end
   endtask : check

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rchk(input logic [5:0] a, input logic [7:0] e, input string what);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, e, what);
   endtask : rchk

   // pins and the read path lag the registers by up to three edges
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      close_out();
   end

   initial begin
      rst = 1'b1;
      {reg_addr, reg_wdata, reg_wr, reg_rd, keypad_one_sel, keypad_one_rise, keypad_two_sel} = '0;
      {serial_en, serial_txd, timer_ch1_own, timer_ch1_oe, timer_ch1_out, spi_en} = '0;
      {spi_oe, spi_out, timer_ch0_own, timer_ch0_oe, timer_ch0_out, debug_oe, debug_out} = '0;
      ext_en  = 40'h0001000000;
      ext_val = 40'h0;
      repeat (3) @(posedge clk);
      rst     <= 1'b0;
      ext_en  <= '1;
      ext_val <= 40'h3C22C35AA6;
      settle();
      check({6'h0, reset_pin_en, debug_pin_en}, 8'h03, "pin functions");
      check(pin_oe[39:32] | pin_oe[31:24] | pin_oe[23:16] | pin_oe[15:8] | pin_oe[7:0],
            8'h00, "enables after reset");
      check(pin_pu[31:24], 8'h01, "debug pullup");
      rchk(FPPIO_CFG_ADDR, 8'h03, "mode select low");
      for (int p = 0; p < 5; p++) begin
         rchk(reg_at(FPPIO_DIR_BASE, p), 8'h00, "direction reset");
         rchk(reg_at(FPPIO_PULL_BASE, p), 8'h00, "pullup reset");
      end
      $display("test reset done");
      for (int p = 0; p < 5; p++) begin
         pat = 8'h96 + 8'(p);
         exp = (p == 3) ? 8'h7C : (p == 0) ? 8'hFE : 8'hFF;
         wr(reg_at(FPPIO_DATA_BASE, p), pat);
         rchk(reg_at(FPPIO_DATA_BASE, p), ext_val[8*p +: 8] & FPPIO_PORT_MASK[p], "pin read");
         check(pin_sync[8*p +: 8], ext_val[8*p +: 8], "peripheral level");
         wr(reg_at(FPPIO_DIR_BASE, p), 8'hFF);
         settle();
         check(pin_oe[8*p +: 8], exp, "drive enable");
         check(pin_out[8*p +: 8] & exp, pat & exp, "drive value");
         rchk(reg_at(FPPIO_DATA_BASE, p), (p == 3) ? ((pat & 8'h7C) | 8'h02) : pat, "latch read");
         wr(reg_at(FPPIO_PULL_BASE, p), 8'hFF);
         wr(reg_at(FPPIO_DIR_BASE, p), 8'h0F);
         settle();
         check(pin_pu[8*p +: 8], (8'hF0 & FPPIO_PORT_MASK[p]) | ((p == 3) ? 8'h01 : 8'h00),
               "pullup on inputs");
      end
      $display("test gpio done");
      for (int p = 1; p < 4; p++) wr(reg_at(FPPIO_DIR_BASE, p), 8'hFF);
      @(posedge clk);
      {serial_en, timer_ch1_own, timer_ch1_oe, spi_en, timer_ch0_own, timer_ch0_out} <= 6'h3F;
      spi_oe  <= 4'hA;
      spi_out <= 4'h6;
      settle();
      check(pin_oe[15:8], 8'hFD, "serial and timer enables");
      check(pin_out[15:8] & 8'h81, 8'h00, "serial and timer values");
      check(pin_oe[23:16], 8'hAF, "spi enables");
      check(pin_out[23:16] & 8'hF0, 8'h60, "spi values");
      check(pin_oe[31:24], 8'h3C, "fourth port owners");
      rchk(reg_at(FPPIO_DATA_BASE, 1), 8'h97, "owned pin latch");
      debug_oe <= 1'b1;
      settle();
      check({5'h0, pin_pu[24], pin_oe[24], pin_out[24]}, 8'h06, "debug drive");
      wr(FPPIO_CFG_ADDR, 8'h02);
      settle();
      check({4'h0, pin_pu[24], pin_oe[24], pin_out[24], debug_pin_en}, 8'h06, "released");
      {serial_en, timer_ch1_own, spi_en, timer_ch0_own, timer_ch0_out, debug_oe} <= '0;
      $display("test peripherals done");
      wr(FPPIO_DIR_BASE, 8'hFF);
      keypad_one_sel <= 8'h0F;
      keypad_two_sel <= 4'hF;
      settle();
      check(pin_oe[7:0], 8'hF0, "keypad one claim");
      check(pin_oe[23:16], 8'hF0, "keypad two claim");
      wr(FPPIO_DIR_BASE, 8'h00);
      keypad_one_sel  <= 8'hFF;
      keypad_one_rise <= 8'hFF;
      settle();
      check(pin_pd[7:0], 8'hF0, "keypad pulldowns");
      check(pin_pu[7:0], 8'h0F, "keypad pullups");
      rchk(6'h3F, 8'h00, "unmapped read");
      $display("test keypad done");
      ext_val[24] <= 1'b1;
      rst         <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      settle();
      rchk(FPPIO_CFG_ADDR, 8'h83, "mode select high");
      rchk(reg_at(FPPIO_DIR_BASE, 4), 8'h00, "direction cleared");
      check(pin_oe[39:32] | pin_oe[23:16] | pin_oe[15:8], 8'h00, "enables cleared");
      $display("test second reset done");
      close_out();
   end
endmodule : fppio_top_test
